// >>> inc/ftoi_pkg.sv
// Constants and types shared by the float-to-integer converter
package ftoi_pkg;
    // Register byte offsets on the APB
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_OPERAND_HI = 8'h04;
    localparam logic [7:0] ADDR_OPERAND_LO = 8'h08;
    localparam logic [7:0] ADDR_COMMAND = 8'h0c;
    localparam logic [7:0] ADDR_RESULT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    localparam logic [7:0] ADDR_CONV_STATE = 8'h1c;
    // Widths
    localparam int STATUS_W = 16;
    localparam int FRAC_W = 56;
    localparam int EXP_W = 8;
    localparam int DIFF_W = 10;
    localparam int SHIFT_W = 5;
    localparam int SHORT_W = 16;
    localparam int LONG_W = 32;
    localparam int SINGLE_FRAC_W = 24;
    localparam int IRQ_W = 2;
    // Floating status register fields
    localparam int FS_NEG_BIT = 3;
    localparam int FS_ZERO_BIT = 2;
    localparam int FS_TRUNC_BIT = 5;
    localparam int FS_LONG_BIT = 6;
    localparam int FS_DOUBLE_BIT = 7;
    localparam int FS_CONV_IE_BIT = 10;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    // Operand word layout
    localparam int OP_SIGN_BIT = 31;
    localparam int OP_EXP_LSB = 23;
    localparam int OP_FRAC_MSB = 22;
    // Command, interrupt and state bits
    localparam int CMD_START_BIT = 0;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ERR_BIT = 1;
    localparam int CS_BUSY_BIT = 0;
    localparam int CS_ERR_BIT = 1;
    // Exponent test constants, excess-200 octal
    localparam logic [9:0] FIRST_TEST_SUB = 10'h081;
    localparam logic [9:0] SHORT_RANGE_SUB = 10'h010;
    localparam logic [9:0] LONG_RANGE_SUB = 10'h020;
    localparam logic [9:0] ONE_SHIFT = 10'h001;
    localparam logic [7:0] SHORT_EDGE_EXP = 8'h90;
    localparam logic [7:0] LONG_EDGE_EXP = 8'ha0;
    localparam logic [7:0] LONG_TOP_EXP = 8'h9f;
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CONVERT = 1'b1
    } ftoi_state_type;
endpackage : ftoi_pkg

// >>> src/ftoi_core.sv
// Combinational range tests, shift, truncation and negation
`timescale 1ns/100ps
`default_nettype none
module ftoi_core
    import ftoi_pkg::*;
(
    input wire logic sign,
    input wire logic [ftoi_pkg::EXP_W-1:0] exponent,
    input wire logic [ftoi_pkg::FRAC_W-1:0] fraction,
    input wire logic double_sel,
    input wire logic long_sel,
    output logic [ftoi_pkg::LONG_W-1:0] result,
    output logic conv_error,
    output logic result_zero,
    output logic result_negative
);
    import ftoi_pkg::*;

    logic [DIFF_W-1:0] first_diff;
    logic [DIFF_W-1:0] range_sub;
    logic [DIFF_W-1:0] range_diff;
    logic [DIFF_W-1:0] shift_full;
    logic [SHIFT_W-1:0] shift;
    logic [FRAC_W-1:0] frac_eff;
    logic [LONG_W-1:0] src;
    logic [LONG_W-1:0] mag;
    logic [LONG_W-1:0] value;
    logic [SHORT_W-1:0] short_neg;
    logic msb;

    // Tests, shift and sign handling in one pass
    always_comb begin
        first_diff = {2'b00, exponent} - FIRST_TEST_SUB;
        range_sub = long_sel ? LONG_RANGE_SUB : SHORT_RANGE_SUB;
        range_diff = first_diff - range_sub;
        shift_full = range_sub + FIRST_TEST_SUB - {2'b00, exponent} - ONE_SHIFT;
        shift = shift_full[SHIFT_W-1:0];
        // Single operands carry no low fraction bits
        frac_eff = double_sel ? fraction : {fraction[FRAC_W-1 -: SINGLE_FRAC_W], 32'h0};
        // Hidden bit plus 15 or 31 fraction bits, or whole single fraction
        src = long_sel ? frac_eff[FRAC_W-1 -: LONG_W] : {16'h0, frac_eff[FRAC_W-1 -: SHORT_W]};
        // Bits shifted out are dropped whatever the truncate mode
        mag = src >> shift;
        short_neg = SHORT_W'(~mag[SHORT_W-1:0] + 16'h0001);
        if (!sign) begin
            value = mag;
        end else if (long_sel) begin
            value = ~mag + 32'h0000_0001;
        end else begin
            value = {16'h0, short_neg};
        end
        msb = long_sel ? value[LONG_W-1] : value[SHORT_W-1];
        if (first_diff[DIFF_W-1]) begin
            result = 32'h0;
            conv_error = 1'b1;
        end else if (!range_diff[DIFF_W-1]) begin
            result = 32'h0;
            conv_error = 1'b1;
        end else begin
            // Edge exponent proceeds; only the sign check catches it
            result = value;
            conv_error = (msb != sign);
        end
        result_zero = (result == 32'h0);
        result_negative = long_sel ? result[LONG_W-1] : result[SHORT_W-1];
    end
endmodule : ftoi_core
`default_nettype wire

// >>> src/ftoi_top.sv
// APB-attached float-to-integer converter with floating status register
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module ftoi_top
    import ftoi_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    import ftoi_pkg::*;

    ftoi_state_type state_q;
    logic [STATUS_W-1:0] float_status_register_q;
    logic [31:0] op_hi_q;
    logic [31:0] op_lo_q;
    logic [LONG_W-1:0] result_q;
    logic [IRQ_W-1:0] irq_st_q;
    logic [IRQ_W-1:0] irq_st_d;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic conv_err_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic irq_q;
    logic wr_take;
    logic rd_take;
    logic start;
    logic [LONG_W-1:0] core_result;
    logic core_error;
    logic core_zero;
    logic core_negative;
    logic [FRAC_W-1:0] fraction;
    logic [EXP_W-1:0] exponent;
    logic sign;
    logic double_precision_select;
    logic long_integer_select;
    logic conversion_interrupt_enable;

    // Address decode for the error answer; the read mux decodes on its own
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == ADDR_STATUS) || (a == ADDR_OPERAND_HI) || (a == ADDR_OPERAND_LO)
            || (a == ADDR_COMMAND) || (a == ADDR_RESULT) || (a == ADDR_IRQ_STATUS)
            || (a == ADDR_IRQ_MASK) || (a == ADDR_CONV_STATE);
    endfunction : addr_mapped

    // Operand fields and mode bits
    assign sign = op_hi_q[OP_SIGN_BIT];
    assign exponent = op_hi_q[OP_SIGN_BIT-1:OP_EXP_LSB];
    assign fraction = {1'b1, op_hi_q[OP_FRAC_MSB:0], op_lo_q};
    assign double_precision_select = float_status_register_q[FS_DOUBLE_BIT];
    assign long_integer_select = float_status_register_q[FS_LONG_BIT];
    assign conversion_interrupt_enable = float_status_register_q[FS_CONV_IE_BIT];

    // Writes take effect on the completing edge, reads on the edge that raises pready
    assign wr_take = psel && penable && pready_q && pwrite;
    assign rd_take = psel && penable && !pready_q && !pwrite;
    assign start = wr_take && (paddr == ADDR_COMMAND) && pwdata[CMD_START_BIT];

    ftoi_core u_core (
        .sign(sign),
        .exponent(exponent),
        .fraction(fraction),
        .double_sel(double_precision_select),
        .long_sel(long_integer_select),
        .result(core_result),
        .conv_error(core_error),
        .result_zero(core_zero),
        .result_negative(core_negative)
    );

    // One wait state: pready is a flop, so the access is two cycles
    always_ff @(posedge clock) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !addr_mapped(paddr);
        end
    end

    // Read data captured on the same edge that raises pready
    always_ff @(posedge clock) begin
        if (rst) begin
            prdata_q <= 32'h0;
        end else if (rd_take) begin
            unique case (paddr)
                ADDR_STATUS: prdata_q <= {16'h0, float_status_register_q};
                ADDR_OPERAND_HI: prdata_q <= op_hi_q;
                ADDR_OPERAND_LO: prdata_q <= op_lo_q;
                ADDR_RESULT: prdata_q <= result_q;
                ADDR_IRQ_STATUS: prdata_q <= {30'h0, irq_st_q};
                ADDR_IRQ_MASK: prdata_q <= {30'h0, irq_mask_q};
                ADDR_CONV_STATE: prdata_q <= {30'h0, conv_err_q, state_q == ST_CONVERT};
                default: prdata_q <= 32'h0;
            endcase
        end
    end

    // Operand registers
    always_ff @(posedge clock) begin
        if (rst) begin
            op_hi_q <= 32'h0;
            op_lo_q <= 32'h0;
        end else if (wr_take && state_q == ST_IDLE) begin
            if (paddr == ADDR_OPERAND_HI) begin
                op_hi_q <= pwdata;
            end
            if (paddr == ADDR_OPERAND_LO) begin
                op_lo_q <= pwdata;
            end
        end
    end

    // Conversion sequencer; a start while busy is ignored
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: state_q <= start ? ST_CONVERT : ST_IDLE;
                ST_CONVERT: state_q <= ST_IDLE;
            endcase
        end
    end

    // Status register: conversion flags outrank a software load
    always_ff @(posedge clock) begin
        if (rst) begin
            float_status_register_q <= STATUS_RESET;
        end else if (state_q == ST_CONVERT) begin
            float_status_register_q[FS_ZERO_BIT] <= core_zero;
            float_status_register_q[FS_NEG_BIT] <= core_negative;
        end else if (wr_take && paddr == ADDR_STATUS) begin
            float_status_register_q <= pwdata[STATUS_W-1:0];
        end
    end

    // Result and last-error record
    always_ff @(posedge clock) begin
        if (rst) begin
            result_q <= 32'h0;
            conv_err_q <= 1'b0;
        end else if (state_q == ST_CONVERT) begin
            result_q <= core_result;
            conv_err_q <= core_error;
        end
    end

    // Sticky events; a set in the clearing cycle wins
    always_comb begin
        irq_set = '0;
        irq_set[IRQ_DONE_BIT] = (state_q == ST_CONVERT);
        irq_set[IRQ_ERR_BIT] = (state_q == ST_CONVERT) && core_error && conversion_interrupt_enable;
        irq_clr = (wr_take && paddr == ADDR_IRQ_STATUS) ? pwdata[IRQ_W-1:0] : '0;
        irq_st_d = (irq_st_q & ~irq_clr) | irq_set;
    end

    // Interrupt status, mask and level output
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_st_q <= '0;
            irq_mask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            irq_st_q <= irq_st_d;
            if (wr_take && paddr == ADDR_IRQ_MASK) begin
                irq_mask_q <= pwdata[IRQ_W-1:0];
            end
            irq_q <= |(irq_st_d & irq_mask_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

    // Checks on conversion and status behaviour
    chk_fraction_zero: assert property (@(posedge clock) disable iff (rst)
        (state_q == ST_CONVERT && exponent < 8'h81)
        |=> (result_q == 32'h0 && conv_err_q && float_status_register_q[FS_ZERO_BIT]))
        else $error("operand below one not zeroed with error");
    chk_range_error: assert property (@(posedge clock) disable iff (rst)
        (state_q == ST_CONVERT && exponent > (long_integer_select ? LONG_EDGE_EXP : SHORT_EDGE_EXP))
        |=> (result_q == 32'h0 && conv_err_q))
        else $error("out of range operand not rejected");
    chk_edge_positive: assert property (@(posedge clock) disable iff (rst)
        (state_q == ST_CONVERT && !sign
            && exponent == (long_integer_select ? LONG_EDGE_EXP : SHORT_EDGE_EXP))
        |=> conv_err_q)
        else $error("positive edge exponent passed sign check");
    chk_edge_most_neg: assert property (@(posedge clock) disable iff (rst)
        (state_q == ST_CONVERT && sign && !long_integer_select && exponent == SHORT_EDGE_EXP
            && fraction[FRAC_W-2 -: SHORT_W-1] == 15'h0)
        |=> (result_q == 32'h0000_8000 && !conv_err_q))
        else $error("most negative short not produced");
    chk_negate_one: assert property (@(posedge clock) disable iff (rst)
        (state_q == ST_CONVERT && sign && exponent == 8'h81)
        |=> (result_q == ($past(long_integer_select) ? 32'hffff_ffff : 32'h0000_ffff)
            && float_status_register_q[FS_NEG_BIT]))
        else $error("minus one not produced");
    chk_long_shift: assert property (@(posedge clock) disable iff (rst)
        (state_q == ST_CONVERT && !sign && long_integer_select && double_precision_select
            && exponent == LONG_TOP_EXP)
        |=> (result_q == {1'b0, $past(fraction[FRAC_W-1 -: LONG_W-1])}))
        else $error("long shift count wrong");
    chk_error_trap: assert property (@(posedge clock) disable iff (rst)
        $rose(irq_st_q[IRQ_ERR_BIT]) |-> ($past(conversion_interrupt_enable) && conv_err_q))
        else $error("conversion trap without enable or error");
    chk_load_status: assert property (@(posedge clock) disable iff (rst)
        (wr_take && paddr == ADDR_STATUS && state_q == ST_IDLE)
        |=> (float_status_register_q == $past(pwdata[STATUS_W-1:0])))
        else $error("status load did not copy 16 bits");
    chk_store_status: assert property (@(posedge clock) disable iff (rst)
        (rd_take && paddr == ADDR_STATUS)
        |=> (prdata_q == {16'h0, $past(float_status_register_q)}
            && float_status_register_q == $past(float_status_register_q)))
        else $error("status store wrong or altered register");
    chk_done_event: assert property (@(posedge clock) disable iff (rst)
        (state_q == ST_CONVERT) |=> (irq_st_q[IRQ_DONE_BIT] && (irq_q || !irq_mask_q[IRQ_DONE_BIT])))
        else $error("done event not recorded");
endmodule : ftoi_top
`default_nettype wire

// >>> sim/ftoi_host.sv
// Host processor model: issues register transfers over APB
`timescale 1ns/100ps
`default_nettype none
module ftoi_host (
    input wire logic clock,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Bus idle at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'hff;
        pwdata = 32'hffffffff;
    end

    // One transfer, held until pready is sampled high; idle bus shows inverted values
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~addr;
        pwdata <= ~wd;
    endtask : xfer
endmodule : ftoi_host
`default_nettype wire

// >>> sim/float_to_int_converter_bench.sv
// Self-checking bench for the float-to-integer converter
`timescale 1ns/100ps
`default_nettype none
module float_to_int_converter_bench;
    import ftoi_pkg::*;
    logic clock;
    logic rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    ftoi_top uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    ftoi_host host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // Clock source
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Hang guard: far above the fewer than one thousand cycles the tests need
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        host.xfer(1'b1, a, d, r, e);
    endtask : wr

    task automatic chk_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        host.xfer(1'b0, a, 32'h0, r, e);
        cmp(what, exp, r);
    endtask : chk_rd

    // Reference conversion: {error, integer}; width-limited magnitude, truncating shift
    function automatic logic [32:0] model(input logic [31:0] hi, input logic [31:0] lo,
                                          input logic dbl, input logic lng);
        logic [55:0] f;
        logic [31:0] m;
        int d;
        int w;
        w = lng ? 32 : 16;
        f = {1'b1, hi[22:0], dbl ? lo : 32'h0};
        d = int'(hi[30:23]) - int'(8'h81);
        if (d < 0 || d - w >= 0) return {1'b1, 32'h0};
        m = lng ? f[55:24] : {16'h0, f[55:40]};
        m = m >> (w - d - 1);
        if (hi[31]) m = lng ? -m : {16'h0, -m[15:0]};
        return {m[w-1] != hi[31], m};
    endfunction : model

    // One conversion with its flags, error record and interrupt raise and clear
    task automatic run_case(input string name, input logic dbl, input logic lng, input logic ie,
                            input logic tr, input logic [31:0] hi, input logic [31:0] lo);
        logic [32:0] e;
        logic [31:0] r;
        logic x;
        logic [15:0] st;
        logic n;
        e = model(hi, lo, dbl, lng);
        n = lng ? e[31] : e[15];
        st = 16'h000c | {5'h0, ie, 2'h0, dbl, lng, tr, 5'h0};
        wr(ADDR_STATUS, {16'h0, st});
        wr(ADDR_OPERAND_HI, hi);
        wr(ADDR_OPERAND_LO, lo);
        wr(ADDR_COMMAND, 32'h1);
        r = 32'h1;
        for (int i = 0; i < 8 && r[0] !== 1'b0; i++) host.xfer(1'b0, ADDR_CONV_STATE, 32'h0, r, x);
        cmp({name, " error"}, {30'h0, e[32], 1'b0}, r);
        chk_rd({name, " result"}, ADDR_RESULT, e[31:0]);
        chk_rd({name, " flags"}, ADDR_STATUS, {16'h0, (st & 16'hfff3) | {12'h0, n, e[31:0] == 32'h0, 2'h0}});
        chk_rd({name, " irq bits"}, ADDR_IRQ_STATUS, {30'h0, e[32] & ie, 1'b1});
        cmp({name, " irq"}, {31'h0, e[32] & ie}, {31'h0, irq});
        wr(ADDR_IRQ_STATUS, 32'h3);
        repeat (2) @(posedge clock);
        cmp({name, " irq clear"}, 32'h0, {31'h0, irq});
        $display("case %s done", name);
    endtask : run_case

    // Reset values, status load/store, unmapped access
    task automatic test_regs();
        logic [31:0] r;
        logic e;
        for (int a = 0; a < 32; a += 4) chk_rd("reset value", 8'(a), 32'h0);
        cmp("reset irq", 32'h0, {31'h0, irq});
        wr(ADDR_STATUS, 32'hffff5a5a);
        chk_rd("status load", ADDR_STATUS, 32'h00005a5a);
        chk_rd("status store", ADDR_STATUS, 32'h00005a5a);
        wr(ADDR_STATUS, 32'h0000a5a5);
        chk_rd("status reload", ADDR_STATUS, 32'h0000a5a5);
        wr(8'h20, 32'h12345678);
        host.xfer(1'b0, 8'h20, 32'h0, r, e);
        cmp("unmapped data", 32'h0, r);
        cmp("unmapped error", 32'h1, {31'h0, e});
        wr(ADDR_IRQ_MASK, 32'h2);
        chk_rd("irq mask", ADDR_IRQ_MASK, 32'h2);
        $display("register test done");
    endtask : test_regs

    // Done event reaching the pin once unmasked, then cleared
    task automatic test_done_event();
        wr(ADDR_IRQ_MASK, 32'h3);
        wr(ADDR_COMMAND, 32'h1);
        repeat (3) @(posedge clock);
        cmp("done irq", 32'h1, {31'h0, irq});
        wr(ADDR_IRQ_STATUS, 32'h3);
        repeat (2) @(posedge clock);
        cmp("done irq clear", 32'h0, {31'h0, irq});
        $display("done event test done");
    endtask : test_done_event

    // Main sequence
    initial begin
        rst = 1'b1;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        test_regs();
        run_case("ss plain", 0, 0, 1, 0, {1'b0, 8'h83, 23'h300000}, 32'h0);
        run_case("ss neg trunc", 0, 0, 0, 1, {1'b1, 8'h82, 23'h7fffff}, 32'h0);
        run_case("ss below one", 0, 0, 1, 0, {1'b0, 8'h80, 23'h7fffff}, 32'h0);
        run_case("ss exp zero", 0, 0, 1, 0, 32'h0, 32'h0);
        run_case("ss range", 0, 0, 1, 0, {1'b0, 8'h91, 23'h0}, 32'h0);
        run_case("ss edge pos", 0, 0, 1, 0, {1'b0, 8'h90, 23'h0}, 32'h0);
        run_case("ds edge neg", 1, 0, 1, 0, {1'b1, 8'h90, 23'h0}, 32'hffffffff);
        run_case("ds top", 1, 0, 0, 0, {1'b0, 8'h8f, 23'h7fffff}, 32'hffffffff);
        run_case("sl whole", 0, 1, 1, 0, {1'b1, 8'h9f, 23'h000001}, 32'hffffffff);
        run_case("dl low", 1, 1, 0, 0, {1'b0, 8'h9f, 23'h0}, 32'hff800000);
        run_case("dl edge", 1, 1, 1, 0, {1'b0, 8'ha0, 23'h0}, 32'h0);
        run_case("sl range", 0, 1, 1, 0, {1'b1, 8'ha1, 23'h0}, 32'h0);
        run_case("dl neg max", 1, 1, 0, 0, {1'b1, 8'ha0, 23'h0}, 32'h0);
        run_case("sl minus one", 0, 1, 0, 0, {1'b1, 8'h81, 23'h7fffff}, 32'h0);
        run_case("dl range quiet", 1, 1, 0, 0, {1'b0, 8'ha4, 23'h0}, 32'h0);
        test_done_event();
        test_done();
    end
endmodule : float_to_int_converter_bench
`default_nettype wire
